// file: spimsb_regs.svh
`ifndef SPIMSB_REGS_SVH
`define SPIMSB_REGS_SVH

// register byte offsets
`define SPIMSB_CTRL_OFS   8'h00
`define SPIMSB_STAT_OFS   8'h04
`define SPIMSB_DATA_OFS   8'h08
`define SPIMSB_AUX_OFS    8'h0c

// control register fields
`define SPIMSB_CTRL_IE    7
`define SPIMSB_CTRL_EN    6
`define SPIMSB_CTRL_LSB   5
`define SPIMSB_CTRL_CTL   4
`define SPIMSB_CTRL_CLOCK_POLARITY_BIT  3
`define SPIMSB_CTRL_CLOCK_PHASE_BIT  2
`define SPIMSB_CTRL_RESET 8'h00

// status register fields
`define SPIMSB_STAT_DONE  7
`define SPIMSB_STAT_COL   6
`define SPIMSB_STAT_DBL   0

// auxiliary register fields
`define SPIMSB_AUX_GATE   0
`define SPIMSB_AUX_SSIN   1
`define SPIMSB_AUX_ACK    2
`define SPIMSB_AUX_MOSIOE 3
`define SPIMSB_AUX_SCKOE  4
`define SPIMSB_AUX_MISOOE 5
`define SPIMSB_AUX_SSVAL  6
`define SPIMSB_AUX_RESET  8'h40

// half sck period minus one, in pclk cycles
`define SPIMSB_HALF_D4    6'd1
`define SPIMSB_HALF_D16   6'd7
`define SPIMSB_HALF_D64   6'd31
`define SPIMSB_HALF_D128  6'd63
`define SPIMSB_HALF_D2    6'd0
`define SPIMSB_HALF_D8    6'd3
`define SPIMSB_HALF_D32   6'd15

// index of the last sck edge and of the last bit in one byte
`define SPIMSB_LAST_EDGE  4'hf
`define SPIMSB_LAST_BIT   3'h7

`endif

// file: spimsb_pkg.sv
package spimsb_pkg;
  // controller engine state
  typedef enum logic [0:0] {
    SPIMSB_IDLE = 1'b0,
    SPIMSB_RUN  = 1'b1
  } spimsb_state_t;
  // {double rate, rate select high, rate select low}
  typedef logic [2:0] spimsb_rate_t;
endpackage

// file: spimsb_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser for pin inputs
module spimsb_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // async in, sync out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;  // first stage, read only by second

  // one flop pair per bit
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule

// file: spimsb_clkdiv.sv
`timescale 1ns/1ns
`include "spimsb_regs.svh"
// half-period tick generator for controller sck
module spimsb_clkdiv (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // control
  input  wire logic                  run,
  input  wire spimsb_pkg::spimsb_rate_t rate,
  // one-cycle pulse per sck half period
  output logic                       tick
);
  import spimsb_pkg::*;

  logic [5:0] cnt_q;   // cycles into this half period
  logic [5:0] half;    // terminal count

  // rate decode
  always_comb
  begin
    unique case (rate)
      3'b000: half = `SPIMSB_HALF_D4;
      3'b001: half = `SPIMSB_HALF_D16;
      3'b010: half = `SPIMSB_HALF_D64;
      3'b011: half = `SPIMSB_HALF_D128;
      3'b100: half = `SPIMSB_HALF_D2;
      3'b101: half = `SPIMSB_HALF_D8;
      3'b110: half = `SPIMSB_HALF_D32;
      3'b111: half = `SPIMSB_HALF_D64;
    endcase
  end

  assign tick = run && (cnt_q == half);

  // counter restarts with every byte so the first half is full length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 6'h00;
    else if (!run || tick)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_q + 6'h01;
  end
endmodule

// file: spimsb_top.sv
// What this block does
// R1 - data write starts eight-bit controller transfer
// R2 - done flag with enable raises interrupt
// R3 - software drives select before controller transfer
// R4 - software writes next byte or ends
// R5 - select low starts packet, high resyncs
// R6 - mosi controller to target, miso back
// R7 - last received byte held in buffer
// R8 - target idle, miso off while deselected
// R9 - target accepts data writes while deselected
// R10 - target byte end sets done flag
// R11 - transmit and receive paths kept separate
// R12 - no data write before shift ends
// R13 - unread byte overwritten by next one
// R14 - target sck phases over two cycles
// R15 - enabled mode forces pin directions
// R16 - power gate bit holds block inert
// R17 - select low in controller mode faults
// R18 - polarity and phase pick sck mode
// R19 - rate bits divide pclk two..128
// R20 - write during transfer sets collision
// R21 - done clears on ack or read-access
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "spimsb_regs.svh"
module spimsb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // interrupt request
  output logic             irq,
  // serial pins, each as in/out/oe
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i,
  output logic             ss_n_o,
  output logic             ss_n_oe
);
  import spimsb_pkg::*;

  // shift one bit in at the msb or lsb end
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b, input logic lsb);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // bit that goes out first
  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[7];
  endfunction

  logic [7:0]    ctrl_q;      // serial control register
  logic [7:0]    aux_q;       // gate, select and pin options
  logic          dbl_q;       // double rate bit
  logic          done_q;      // transfer done flag
  logic          col_q;       // write collision flag
  logic          arm_done_q;  // status read saw done
  logic          arm_col_q;   // status read saw collision
  logic [7:0]    sh_q;        // shift register
  logic [7:0]    tx_q;        // last accepted transmit byte
  logic [7:0]    rx_q;        // receive buffer
  logic          out_q;       // serial output bit
  logic          sck_q;       // controller sck level
  logic [3:0]    edge_q;      // controller sck edge index
  logic [2:0]    cnt_q;       // target bits received
  spimsb_state_t st_q;        // controller engine
  logic [31:0]   prdata_q;    // read data, set in setup phase
  logic [3:0]    pins_s;      // synchronised pins
  logic          sck_p_q;     // previous synchronised sck
  logic          tick;        // controller half period
  logic [1:0]    cs_d_q;      // controller sample strobe, delayed
  logic [1:0]    cl_d_q;      // controller byte end, delayed
  logic [7:0]    crx_q;       // controller receive shifter

  // pin inputs pass two flops
  spimsb_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({~ss_n_i, miso_i, mosi_i, sck_i}),
    .sync_o  (pins_s)
  );

  logic sck_s, mosi_s, miso_s, ss_s;
  // select passes inverted, so a freshly reset synchroniser reads as
  // deselected instead of a false select pulse
  assign {ss_s, miso_s, mosi_s, sck_s} = {~pins_s[3], pins_s[2:0]};

  // mode decode; the gate bit blocks both modes
  logic en, ctl, tgt, lsb, clock_polarity_bit, clock_phase_bit, ss_low;
  assign en     = ctrl_q[`SPIMSB_CTRL_EN] && !aux_q[`SPIMSB_AUX_GATE]; // [R16]
  assign ctl    = en && ctrl_q[`SPIMSB_CTRL_CTL];
  assign tgt    = en && !ctrl_q[`SPIMSB_CTRL_CTL];
  assign lsb    = ctrl_q[`SPIMSB_CTRL_LSB];
  assign clock_polarity_bit   = ctrl_q[`SPIMSB_CTRL_CLOCK_POLARITY_BIT];
  assign clock_phase_bit   = ctrl_q[`SPIMSB_CTRL_CLOCK_PHASE_BIT];
  assign ss_low = !ss_s;

  // apb decode
  logic acc, wr, rd, hit_ctrl, hit_stat, hit_data, hit_aux, mapped;
  assign acc      = psel && penable;
  assign wr       = acc && pwrite;
  assign rd       = acc && !pwrite;
  assign hit_ctrl = paddr == `SPIMSB_CTRL_OFS;
  assign hit_stat = paddr == `SPIMSB_STAT_OFS;
  assign hit_data = paddr == `SPIMSB_DATA_OFS;
  assign hit_aux  = paddr == `SPIMSB_AUX_OFS;
  assign mapped   = hit_ctrl || hit_stat || hit_data || hit_aux;
  assign pready   = 1'b1;
  assign pslverr  = acc && !mapped;
  assign prdata   = prdata_q;

  // controller faulted by select pulled low as an input
  logic fault;
  assign fault = ctl && aux_q[`SPIMSB_AUX_SSIN] && ss_low; // [R17]

  // transfer in progress; only deselected target or idle take data
  logic busy, data_wr, accept, start;
  assign busy    = (st_q == SPIMSB_RUN) || (|cl_d_q) || (tgt && ss_low);
  assign data_wr = wr && hit_data;
  assign accept  = data_wr && !busy && en;                    // [R9] [R11]
  assign start   = accept && ctl && !fault;                   // [R1]

  // controller edges: leading edges have even index
  logic c_samp, c_setup, c_last;
  assign c_samp  = tick && (edge_q[0] == clock_phase_bit);               // [R18]
  assign c_setup = tick && (edge_q[0] != clock_phase_bit);
  assign c_last  = tick && (edge_q == `SPIMSB_LAST_EDGE);

  // target edges found from the sampled sck
  logic rise, fall, lead, trail, t_act, t_samp, t_setup, t_last;
  assign rise    = sck_s && !sck_p_q;
  assign fall    = !sck_s && sck_p_q;
  assign lead    = clock_polarity_bit ? fall : rise;
  assign trail   = clock_polarity_bit ? rise : fall;
  assign t_act   = tgt && ss_low;                             // [R8] [R5]
  assign t_samp  = t_act && (clock_phase_bit ? trail : lead);            // [R18]
  assign t_setup = t_act && (clock_phase_bit ? lead : trail);
  assign t_last  = t_samp && (cnt_q == `SPIMSB_LAST_BIT);

  logic in_bit, byte_done;
  assign in_bit    = ctl ? miso_s : mosi_s;                   // [R6]
  assign byte_done = cl_d_q[1] || t_last;

  // sck half period divider
  spimsb_clkdiv u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (st_q == SPIMSB_RUN),
    .rate    ({dbl_q, ctrl_q[1:0]}),                          // [R19]
    .tick    (tick)
  );

  // previous sck sample for edge finding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sck_p_q <= 1'b0;
    else
      sck_p_q <= sck_s;
  end

  // controller engine: sixteen sck edges then stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= SPIMSB_IDLE;
      edge_q <= 4'h0;
      sck_q  <= 1'b0;
    end
    else if (!ctl || fault)
    begin
      // abort and park the clock at its idle level
      st_q   <= SPIMSB_IDLE;
      edge_q <= 4'h0;
      sck_q  <= clock_polarity_bit;
    end
    else
    begin
      unique case (st_q)
        SPIMSB_IDLE:
        begin
          sck_q  <= clock_polarity_bit;                                     // [R18]
          edge_q <= 4'h0;
          if (start)
            st_q <= SPIMSB_RUN;                               // [R1]
        end
        SPIMSB_RUN:
        begin
          if (tick)
          begin
            sck_q  <= ~sck_q;
            edge_q <= edge_q + 4'h1;
          end
          if (c_last)
            st_q <= SPIMSB_IDLE;                              // [R1]
        end
      endcase
    end
  end

  // target bit counter, cleared whenever deselected
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 3'h0;
    else if (!t_act)
      cnt_q <= 3'h0;                                          // [R8]
    else if (t_samp)
      cnt_q <= cnt_q + 3'h1;
  end

  // shift register and transmit copy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_q <= 8'h00;
      tx_q <= 8'h00;
    end
    else if (accept)
    begin
      sh_q <= pwdata[7:0];                                    // [R9]
      tx_q <= pwdata[7:0];
    end
    else if (c_samp || t_samp)
      sh_q <= shift_in(sh_q, in_bit, lsb);
    else if (tgt && !ss_low && cnt_q != 3'h0)
      sh_q <= tx_q;  // partial byte dropped on deselect
  end

  // output bit: first bit early, then on each setup edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= 1'b0;
    else if (accept)
      out_q <= out_bit(pwdata[7:0], lsb);
    else if (c_setup || t_setup || (tgt && !ss_low))
      out_q <= out_bit(sh_q, lsb);
  end

  // miso shows two pclk late through the synchroniser; at fast rates
  // the far side has moved the pin again by then, so the controller
  // samples two cycles after its own sck edge and ends the byte later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_d_q <= 2'b00;
      cl_d_q <= 2'b00;
    end
    else
    begin
      cs_d_q <= {cs_d_q[0], c_samp && ctl};
      cl_d_q <= {cl_d_q[0], c_last && ctl && !fault};
    end
  end

  // controller receive shifter, fed by the delayed strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crx_q <= 8'h00;
    else if (cs_d_q[1])
      crx_q <= shift_in(crx_q, miso_s, lsb);                  // [R6]
  end

  // receive buffer; an unread byte is simply overwritten
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_q <= 8'h00;
    else if (t_last)
      rx_q <= shift_in(sh_q, in_bit, lsb);                    // [R7] [R13]
    else if (cl_d_q[1])
      rx_q <= cs_d_q[1] ? shift_in(crx_q, miso_s, lsb)
                        : crx_q;                              // [R7] [R13]
  end

  // control register; the fault drops controller mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= `SPIMSB_CTRL_RESET;
    else
    begin
      if (wr && hit_ctrl)
        ctrl_q <= pwdata[7:0];
      if (fault)
        ctrl_q[`SPIMSB_CTRL_CTL] <= 1'b0;                     // [R17]
    end
  end

  // aux register and double rate bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aux_q <= `SPIMSB_AUX_RESET;
      dbl_q <= 1'b0;
    end
    else
    begin
      if (wr && hit_aux)
        aux_q <= pwdata[7:0] & ~(8'h01 << `SPIMSB_AUX_ACK);
      if (wr && hit_stat)
        dbl_q <= pwdata[`SPIMSB_STAT_DBL];
    end
  end

  // flags: arm on status read, clear on data access; set wins
  logic data_acc, ack;
  assign data_acc = acc && hit_data;
  assign ack      = wr && hit_aux && pwdata[`SPIMSB_AUX_ACK];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q     <= 1'b0;
      col_q      <= 1'b0;
      arm_done_q <= 1'b0;
      arm_col_q  <= 1'b0;
    end
    else
    begin
      if (byte_done || fault)
        done_q <= 1'b1;                                       // [R10] [R17]
      else if (ack || (data_acc && arm_done_q))
        done_q <= 1'b0;                                       // [R21]
      if (data_wr && busy)
        col_q <= 1'b1;                                        // [R20]
      else if (data_acc && arm_col_q)
        col_q <= 1'b0;                                        // [R20]
      if (rd && hit_stat)
      begin
        arm_done_q <= done_q;
        arm_col_q  <= col_q;
      end
      else if (data_acc)
      begin
        arm_done_q <= 1'b0;
        arm_col_q  <= 1'b0;
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= 32'h0000_0000;
      if (hit_ctrl)
        prdata_q[7:0] <= ctrl_q;
      else if (hit_stat)
        prdata_q[7:0] <= {done_q, col_q, 5'h00, dbl_q};
      else if (hit_data)
        prdata_q[7:0] <= rx_q;
      else if (hit_aux)
        prdata_q[7:0] <= aux_q;
    end
  end

  assign irq = done_q && ctrl_q[`SPIMSB_CTRL_IE];             // [R2]

  // pin drive, overridden by mode while enabled
  assign sck_o   = sck_q;
  assign mosi_o  = out_q;                                     // [R6]
  assign miso_o  = out_q;
  assign ss_n_o  = aux_q[`SPIMSB_AUX_SSVAL];
  assign sck_oe  = ctl && aux_q[`SPIMSB_AUX_SCKOE];           // [R15]
  assign mosi_oe = ctl && aux_q[`SPIMSB_AUX_MOSIOE];          // [R15]
  assign ss_n_oe = ctl && !aux_q[`SPIMSB_AUX_SSIN];           // [R15]
  assign miso_oe = t_act && aux_q[`SPIMSB_AUX_MISOOE];        // [R8] [R15]

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_irq;
    $rose(done_q) && ctrl_q[`SPIMSB_CTRL_IE] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // [R2]

  property p_end;
    (st_q == SPIMSB_RUN) && tick && edge_q == 4'hf && ctl && !fault
      |=> st_q == SPIMSB_IDLE && sck_o == clock_polarity_bit ##2 done_q;
  endproperty
  a_end: assert property (p_end) else $error("byte end wrong"); // [R1]

  property p_idle;
    ctl && st_q == SPIMSB_IDLE |=> sck_o == $past(clock_polarity_bit);
  endproperty
  a_idle: assert property (p_idle) else $error("sck not idle"); // [R18]

  property p_miso_off;
    tgt && ss_s |-> !miso_oe;
  endproperty
  a_miso_off: assert property (p_miso_off) else $error("miso on"); // [R8]

  property p_pins;
    ctl |-> !miso_oe;
  endproperty
  a_pins: assert property (p_pins) else $error("miso driven"); // [R15]

  property p_gate;
    aux_q[`SPIMSB_AUX_GATE] |=> st_q == SPIMSB_IDLE && !miso_oe;
  endproperty
  a_gate: assert property (p_gate) else $error("gated but active"); // [R16]

  property p_fault;
    fault |=> !ctrl_q[`SPIMSB_CTRL_CTL] && done_q;
  endproperty
  a_fault: assert property (p_fault) else $error("fault ignored"); // [R17]

  property p_col;
    data_wr && st_q == SPIMSB_RUN |=> col_q && $stable(tx_q);
  endproperty
  a_col: assert property (p_col) else $error("collision lost"); // [R20]

  property p_tgt_done;
    t_last |=> done_q && rx_q == $past(shift_in(sh_q, in_bit, lsb));
  endproperty
  a_tgt_done: assert property (p_tgt_done) else $error("rx lost"); // [R10]

  property p_tx_load;
    data_wr && tgt && ss_s |=> tx_q == $past(pwdata[7:0]);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx refused"); // [R9]

  c_ctl_byte: cover property (c_last);
  c_tgt_byte: cover property (t_last);
  c_fault: cover property (fault);
endmodule

// file: spimsb_peer.sv
`timescale 1ns/1ns
// far-side device: a target model plus controller tasks
module spimsb_peer (
  // resolved link lines
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       miso,
  input  wire logic       ss_n,
  // mode and the byte sent back as target
  input  wire logic       clock_polarity_bit,
  input  wire logic       clock_phase_bit,
  input  wire logic [7:0] reply,
  // far-side drivers
  output logic            t_miso,
  output logic      [7:0] t_rx,
  output logic            c_sck,
  output logic            c_mosi,
  output logic            c_ss_n
);
  logic [7:0] sh;  // target shift register
  initial
  begin
    sh = 8'h00;
    t_rx = 8'h00;
    t_miso = 1'b0;
    c_sck = 1'b0;
    c_mosi = 1'b0;
    c_ss_n = 1'b1;
  end
  // select frames the byte; released miso must not hold its value
  always @(ss_n)
  begin
    sh = reply;
    t_miso = ss_n ? ~t_miso : reply[7];
  end
  // sample on one edge, shift on the other
  always @(sck)
  begin
    if (!ss_n && ((sck != clock_polarity_bit) ^ clock_phase_bit))
      t_rx = {t_rx[6:0], mosi};
    else if (!ss_n)
    begin
      if (clock_phase_bit)
        t_miso = sh[7];
      sh = sh << 1;
      if (!clock_phase_bit)
        t_miso = sh[7];
    end
  end
  // drive the select line alone
  task automatic sel(input logic v);
    c_ss_n = v;
  endtask
  // one byte as controller; 80 ns phases, far above two pclk
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    c_sck = clock_polarity_bit;
    #80;  // idle level settles before select falls
    c_ss_n = 1'b0;
    c_mosi = tx[7];
    #80;
    for (int i = 7; i >= 0; i--)
    begin
      c_sck = ~clock_polarity_bit;
      if (clock_phase_bit)
        c_mosi = tx[i];
      else
        rx[i] = miso;
      #80;
      c_sck = clock_polarity_bit;
      if (clock_phase_bit)
        rx[i] = miso;
      else if (i > 0)
        c_mosi = tx[i-1];
      #80;
    end
    c_ss_n = 1'b1;
    c_mosi = ~c_mosi;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
`include "spimsb_regs.svh"
module testbench;
  localparam logic [7:0] o_ctl = `SPIMSB_CTRL_OFS;
  localparam logic [7:0] o_st  = `SPIMSB_STAT_OFS;
  localparam logic [7:0] o_dat = `SPIMSB_DATA_OFS;
  localparam logic [7:0] o_aux = `SPIMSB_AUX_OFS;
  // design pins and bench state
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, lf, ptx, b, r, t_rx;
  logic [31:0] pwdata, prdata, rdat;
  logic        irq, rerr, sck_o, sck_oe, mosi_o, mosi_oe, miso_o;
  logic        miso_oe, ss_n_o, ss_n_oe, t_miso, c_sck, c_mosi, c_ss_n;
  logic        clock_polarity_bit, clock_phase_bit, sck_p;
  int          n_mismatch, cmp_count, cyc, gcnt, gmin, gmax, ntog, n;
  // resolved lines: the enabled driver wins
  wire sck_l  = sck_oe ? sck_o : c_sck;
  wire mosi_l = mosi_oe ? mosi_o : c_mosi;
  wire miso_l = miso_oe ? miso_o : t_miso;
  wire ss_l   = ss_n_oe ? ss_n_o : c_ss_n;
  spimsb_top DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .irq, .sck_i(sck_l), .sck_o,
    .sck_oe, .mosi_i(mosi_l), .mosi_o, .mosi_oe, .miso_i(miso_l),
    .miso_o, .miso_oe, .ss_n_i(ss_l), .ss_n_o, .ss_n_oe
  );
  spimsb_peer peer (
    .sck(sck_l), .mosi(mosi_l), .miso(miso_l), .ss_n(ss_l), .clock_polarity_bit,
    .clock_phase_bit, .reply(ptx), .t_miso, .t_rx, .c_sck, .c_mosi, .c_ss_n
  );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // lfsr step for random bytes
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // sck half period in pclk for {double, rate}
  function automatic int half(input int k);
    int t[8] = '{2, 8, 32, 64, 1, 4, 16, 32};
    return t[k];
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer; ends off the edge so effects have landed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  // bounded wait for the done interrupt
  task automatic wirq();
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge pclk);
      n++;
    end
    @(negedge pclk);
  endtask
  // sck gap monitor and hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    sck_p <= sck_o;
    gcnt <= gcnt + 1;
    if (sck_o !== sck_p)
    begin
      gcnt <= 1;
      ntog <= ntog + 1;
      if (ntog > 0 && gcnt < gmin)
        gmin <= gcnt;
      if (ntog > 0 && gcnt > gmax)
        gmax <= gcnt;
    end
    if (cyc == 40000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {clock_polarity_bit, clock_phase_bit, sck_p, cyc, n_mismatch, cmp_count, gcnt, ntog} = '0;
    lf = 8'h3a;
    ptx = 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and an unmapped place
    apb(0, o_ctl, 0);
    chk("ctrl", rdat, 0);
    apb(0, o_aux, 0);
    chk("aux", rdat, 32'h40);
    apb(1, 8'h10, 32'hff);
    apb(0, 8'h10, 0);
    chk("unmapped", {rerr, rdat[30:0]}, 32'h80000000);
    // gated block must ignore a data write
    apb(1, o_aux, 32'h59);
    apb(1, o_ctl, 32'hd0);
    apb(1, o_dat, 32'ha5);
    repeat (40) @(posedge pclk);
    apb(0, o_st, 0);
    chk("gated", {sck_oe, irq, rdat[7:0]}, 0);
    // controller: every mode and every rate
    for (int i = 0; i < 8; i++)
    begin
      {clock_polarity_bit, clock_phase_bit} = i[1:0];
      apb(1, o_ctl, {24'h0, 4'hd, i[1:0], i[1:0]});
      apb(1, o_st, {31'h0, i[2]});
      lf = nxt(lf);
      ptx = lf;
      lf = nxt(lf);
      b = lf;
      apb(1, o_aux, 32'h18);
      {ntog, gmax} = '0;
      gmin = 999;
      apb(1, o_dat, {24'h0, b});
      wirq();
      chk("irq", irq, 1);
      chk("toggles", ntog, 16);
      chk("half min", gmin, half(i));
      chk("half max", gmax, half(i));
      chk("idle sck", sck_o, clock_polarity_bit);
      chk("miso oe", miso_oe, 0);
      chk("peer rx", t_rx, b);
      apb(0, o_st, 0);
      chk("status", rdat, 32'h80 | i[2]);
      apb(0, o_dat, 0);
      chk("rx", rdat, ptx);
      chk("irq off", irq, 0);
      apb(1, o_aux, 32'h58);
    end
    // collision mid-byte, ack, then an unread byte overwritten
    {clock_polarity_bit, clock_phase_bit} = 2'b00;
    apb(1, o_ctl, 32'hd0);
    apb(1, o_st, 32'h1);
    ptx = 8'h3c;
    apb(1, o_aux, 32'h18);
    apb(1, o_dat, 32'h96);
    apb(1, o_dat, 32'h69);
    wirq();
    chk("kept tx", t_rx, 8'h96);
    apb(0, o_st, 0);
    chk("collision", rdat, 32'hc1);
    apb(1, o_aux, 32'h5c);
    chk("irq ack", irq, 0);
    ptx = 8'he1;
    apb(1, o_aux, 32'h18);
    apb(1, o_dat, 32'h0f);
    wirq();
    apb(0, o_st, 0);
    chk("col clear", rdat, 32'h81);
    apb(0, o_dat, 0);
    chk("overwrite", rdat, 32'he1);
    // select driven low by another controller
    apb(1, o_aux, 32'h1a);
    peer.sel(1'b0);
    wirq();
    peer.sel(1'b1);
    apb(0, o_ctl, 0);
    chk("demoted", {sck_oe, mosi_oe, rdat[29:0]}, 32'hc0);
    apb(0, o_st, 0);
    chk("fault done", rdat[7], 1);
    apb(0, o_dat, 0);
    // target: every mode, next byte queued before rx is read
    apb(1, o_aux, 32'h60);
    for (int i = 0; i < 4; i++)
    begin
      {clock_polarity_bit, clock_phase_bit} = i[1:0];
      apb(1, o_ctl, {24'h0, 4'hc, i[1:0], 2'b00});
      if (i == 0)
        apb(1, o_dat, {24'h0, b});
      chk("miso idle", miso_oe, 0);
      lf = nxt(lf);
      peer.xfer(lf, r);
      wirq();
      chk("tgt tx", r, b);
      chk("tgt irq", irq, 1);
      ptx = lf;
      lf = nxt(lf);
      b = lf;
      apb(1, o_dat, {24'h0, b});
      apb(0, o_st, 0);
      chk("tgt status", rdat[7:6], 2'b10);
      apb(0, o_dat, 0);
      chk("tgt rx", rdat, ptx);
    end
    conclude();
  end
endmodule
